/* File: logic/lsm_pkg.sv */
// Constants and register map of the light setpoint manager
// Notes on behaviour
// R1: Brightness above upper limit during shift ends shift, stops ch1, adopts upper limit.
// R2: Brightness below lower limit during shift ends shift, stops ch1, adopts lower limit.
// R3: Temporary shift holds only until the control phase ends, then old setpoint returns.
// R4: Permanent shift holds until preset, new shift, teach or setpoint reset.
// R5: Permanent setpoint survives loss and return of bus supply.
// R6: Optionally, configuration download forces the setpoint to the configured default.
// R7: With teach enabled, an active teach telegram stores measured brightness as setpoint.
// R8: Teach polarity: 1 active, 0 active, or both values active.
// R9: Inactive teach value restores configured setpoint and drops the learned one.
// R10: With both values active, teach cannot restore the configured setpoint.
// R11: Feedback object shows effective setpoint, the lower bound of the range.
// R12: Active feedback sends on change, download and supply return; passive only readable.
// R13: One to three output channels per configured count; channel 1 always present.
// R14: Sender shifts with 4-bit dimming telegrams and ends with stop, relayed to ch1.
// R15: Upper range bound is setpoint raised by hysteresis percent, 10 to 50.
// R16: Setpoint and learned flag sit in retained storage across supply loss.
package lsm_pkg;
   localparam logic [11:0] LSM_CTRL_OFS   = 12'h000;
   localparam logic [11:0] LSM_DEFSP_OFS  = 12'h004;
   localparam logic [11:0] LSM_ULIM_OFS   = 12'h008;
   localparam logic [11:0] LSM_LLIM_OFS   = 12'h00c;
   localparam logic [11:0] LSM_HYST_OFS   = 12'h010;
   localparam logic [11:0] LSM_MEAS_OFS   = 12'h014;
   localparam logic [11:0] LSM_CMD_OFS    = 12'h018;
   localparam logic [11:0] LSM_PRESET_OFS = 12'h01c;
   localparam logic [11:0] LSM_SP_OFS     = 12'h020;
   localparam logic [11:0] LSM_UPPER_OFS  = 12'h024;
   localparam logic [11:0] LSM_STAT_OFS   = 12'h028;
   localparam logic [11:0] LSM_IRQ_OFS    = 12'h02c;
   localparam logic [11:0] LSM_MASK_OFS   = 12'h030;
   localparam logic [11:0] LSM_FB_OFS     = 12'h034;
   // Control register fields
   localparam int CTRL_SHIFT_EN  = 0;
   localparam int CTRL_PERM      = 1;
   localparam int CTRL_TEACH_EN  = 2;
   localparam int CTRL_POL_LO    = 3;
   localparam int CTRL_FB_EN     = 5;
   localparam int CTRL_FB_ACTIVE = 6;
   localparam int CTRL_OVR_DL    = 7;
   localparam int CTRL_NCH_LO    = 8;
   localparam int CTRL_PHASE     = 10;
   // Command register fields (write one to act)
   localparam int CMD_SHIFT      = 0;
   localparam int CMD_TEACH      = 1;
   localparam int CMD_TEACH_VAL  = 2;
   localparam int CMD_RESET      = 3;
   localparam int CMD_DOWNLOAD   = 4;
   localparam int CMD_VRETURN    = 5;
   localparam int CMD_DIM_LO     = 8;
   // Interrupt bits
   localparam int IRQ_ULIM = 0;
   localparam int IRQ_LLIM = 1;
   localparam int IRQ_SPCH = 2;
   localparam int IRQ_FB   = 3;
   localparam int IRQ_W    = 4;
   // Reset values and hysteresis limits
   localparam logic [15:0] DEF_SETPOINT = 16'h0258;
   localparam logic [15:0] DEF_ULIM     = 16'h07d0;
   localparam logic [15:0] DEF_LLIM     = 16'h000a;
   localparam logic [5:0]  DEF_HYST     = 6'h0a;
   localparam logic [5:0]  HYST_MIN     = 6'h0a;
   localparam logic [5:0]  HYST_MAX     = 6'h32;
   localparam logic [10:0] CTRL_RST     = 11'h082;
   localparam logic [3:0]  DIM_STOP     = 4'h0;
   typedef enum logic [1:0] {
      LSM_POL_HI   = 2'b00,
      LSM_POL_LO   = 2'b01,
      LSM_POL_BOTH = 2'b10
   } lsm_pol_e;
   typedef enum logic [1:0] {
      LSM_SRC_CFG   = 2'b00,
      LSM_SRC_EXT   = 2'b01,
      LSM_SRC_TEACH = 2'b10,
      LSM_SRC_SHIFT = 2'b11
   } lsm_src_e;
endpackage : lsm_pkg

/* File: logic/lsm_sync.sv */
// Two-stage synchroniser for a level input
`timescale 1ns/1ps
module lsm_sync import lsm_pkg::*; (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'b0;
         dout   <= 1'b0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : lsm_sync

/* File: logic/lsm_upper.sv */
// Upper bound of the setpoint range from setpoint and hysteresis
`timescale 1ns/1ps
module lsm_upper import lsm_pkg::*; (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [15:0] setpoint,
   input  wire logic [5:0]  hyst,
   output logic [16:0]      upper_q
);
   logic [5:0]  hyst_c;
   logic [21:0] prod;

   always_comb begin
      hyst_c = hyst;
      if (hyst < HYST_MIN) begin
         hyst_c = HYST_MIN;
      end else if (hyst > HYST_MAX) begin
         hyst_c = HYST_MAX;
      end
      prod = 22'(setpoint) * 22'(hyst_c);
   end

   // Setpoint plus percent of setpoint
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_q <= 17'h0;
      end else begin
         upper_q <= 17'(setpoint) + 17'(prod / 22'd100); // see R15
      end
   end
endmodule : lsm_upper

/* File: logic/lsm_top.sv */
// APB-facing light setpoint manager
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module lsm_top import lsm_pkg::*; (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        phase_end_pin,
   output logic             irq,
   output logic [2:0]       ch_en,
   output logic [3:0]       ch1_dim_q,
   output logic             ch1_dim_send_q,
   output logic [15:0]      fb_value_q,
   output logic             fb_send_q
);
   // ==========================================================
   // Registers
   logic [10:0] ctrl_q;
   logic [15:0] defsp_q;
   logic [15:0] ulim_q;
   logic [15:0] llim_q;
   logic [5:0]  hyst_q;
   logic [15:0] meas_q;
   logic [15:0] sp_q;
   logic [15:0] prev_sp_q;
   lsm_src_e    src_q;
   logic        learned_q;
   logic        shifting_q;
   logic        temp_q;
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] mask_q;
   logic [16:0] upper;
   logic        phase_end_s;
   logic        phase_end_d1_q;
   logic        fb_ev_q;

   logic        wr;
   logic        rd;
   logic        mapped;
   logic        cmd_wr;
   logic        pre_wr;
   logic        stat_rd;
   lsm_pol_e    pol;
   logic        shift_on;
   logic        teach_on;
   logic        teach_act;
   logic        teach_inact;
   logic        hit_up;
   logic        hit_lo;
   logic        phase_end;
   logic        dim_stop;
   logic        dl_ev;
   logic        vr_ev;
   logic        sp_chg;
   logic [IRQ_W-1:0] ev;

   assign wr      = psel && penable && pwrite;
   assign rd      = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign cmd_wr  = wr && paddr == LSM_CMD_OFS;
   assign pre_wr  = wr && paddr == LSM_PRESET_OFS;
   assign stat_rd = rd && paddr == LSM_IRQ_OFS;
   assign pol     = lsm_pol_e'(ctrl_q[CTRL_POL_LO +: 2]);
   assign shift_on = ctrl_q[CTRL_SHIFT_EN];
   assign teach_on = ctrl_q[CTRL_TEACH_EN];
   assign dl_ev   = cmd_wr && pwdata[CMD_DOWNLOAD];
   assign vr_ev   = cmd_wr && pwdata[CMD_VRETURN]; // see R5

   // Teach value decoding by polarity
   always_comb begin
      teach_act   = 1'b0;
      teach_inact = 1'b0;
      if (cmd_wr && pwdata[CMD_TEACH] && teach_on) begin
         case (pol)
            LSM_POL_HI: begin
               teach_act   = pwdata[CMD_TEACH_VAL]; // see R8
               teach_inact = !pwdata[CMD_TEACH_VAL];
            end
            LSM_POL_LO: begin
               teach_act   = !pwdata[CMD_TEACH_VAL]; // see R8
               teach_inact = pwdata[CMD_TEACH_VAL];
            end
            LSM_POL_BOTH: begin
               teach_act   = 1'b1; // see R10
               teach_inact = 1'b0;
            end
            default: begin
               teach_act   = 1'b0;
               teach_inact = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Shift limit detection and phase end
   lsm_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (phase_end_pin),
      .dout    (phase_end_s)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_end_d1_q <= 1'b0;
      end else begin
         phase_end_d1_q <= phase_end_s;
      end
   end

   assign phase_end = phase_end_s && !phase_end_d1_q;
   assign hit_up    = shifting_q && meas_q > ulim_q; // see R1
   assign hit_lo    = shifting_q && meas_q < llim_q; // see R2
   assign dim_stop  = cmd_wr && pwdata[CMD_SHIFT] && pwdata[CMD_DIM_LO +: 3] == 3'h0;

   // ==========================================================
   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= CTRL_RST;
         defsp_q <= DEF_SETPOINT;
         ulim_q  <= DEF_ULIM;
         llim_q  <= DEF_LLIM;
         hyst_q  <= DEF_HYST;
         meas_q  <= 16'h0;
         mask_q  <= '0;
      end else if (wr) begin
         case (paddr)
            LSM_CTRL_OFS:  ctrl_q  <= pwdata[10:0];
            LSM_DEFSP_OFS: defsp_q <= pwdata[15:0];
            LSM_ULIM_OFS:  ulim_q  <= pwdata[15:0];
            LSM_LLIM_OFS:  llim_q  <= pwdata[15:0];
            LSM_HYST_OFS:  hyst_q  <= pwdata[5:0];
            LSM_MEAS_OFS:  meas_q  <= pwdata[15:0];
            LSM_MASK_OFS:  mask_q  <= pwdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Setpoint state, reset only asynchronously, supply return keeps it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_q       <= DEF_SETPOINT;
         prev_sp_q  <= DEF_SETPOINT;
         src_q      <= LSM_SRC_CFG;
         learned_q  <= 1'b0;
         shifting_q <= 1'b0;
         temp_q     <= 1'b0;
      end else begin
         if (hit_up) begin
            sp_q       <= ulim_q; // see R1
            shifting_q <= 1'b0;
         end else if (hit_lo) begin
            sp_q       <= llim_q; // see R2
            shifting_q <= 1'b0;
         end else if (teach_act) begin
            sp_q       <= meas_q; // see R7
            src_q      <= LSM_SRC_TEACH;
            learned_q  <= 1'b1; // see R16
            shifting_q <= 1'b0;
            temp_q     <= 1'b0;
         end else if (teach_inact || (cmd_wr && pwdata[CMD_RESET])) begin
            sp_q       <= defsp_q; // see R9
            src_q      <= LSM_SRC_CFG;
            learned_q  <= 1'b0;
            shifting_q <= 1'b0;
            temp_q     <= 1'b0; // see R4
         end else if (dl_ev && ctrl_q[CTRL_OVR_DL]) begin
            sp_q      <= defsp_q; // see R6
            src_q     <= LSM_SRC_CFG;
            learned_q <= 1'b0;
            temp_q    <= 1'b0;
         end else if (pre_wr) begin
            sp_q       <= pwdata[15:0]; // see R4
            src_q      <= LSM_SRC_EXT;
            shifting_q <= 1'b0;
            temp_q     <= 1'b0;
         end else if (cmd_wr && pwdata[CMD_SHIFT] && shift_on) begin
            if (dim_stop) begin
               shifting_q <= 1'b0; // see R14
               sp_q       <= meas_q;
            end else begin
               if (!shifting_q && !temp_q) begin
                  prev_sp_q <= sp_q;
               end
               shifting_q <= 1'b1;
               src_q      <= LSM_SRC_SHIFT;
               temp_q     <= !ctrl_q[CTRL_PERM]; // see R3
            end
         end else if (phase_end && temp_q) begin
            sp_q       <= prev_sp_q; // see R3
            shifting_q <= 1'b0;
            temp_q     <= 1'b0;
         end
      end
   end

   assign sp_chg = hit_up || hit_lo || teach_act || teach_inact || pre_wr ||
                   (cmd_wr && pwdata[CMD_RESET]) || (dl_ev && ctrl_q[CTRL_OVR_DL]) ||
                   (dim_stop && shift_on) || (phase_end && temp_q);

   lsm_upper u_upper (
      .pclk     (pclk),
      .presetn  (presetn),
      .setpoint (sp_q),
      .hyst     (hyst_q),
      .upper_q  (upper)
   );

   // ==========================================================
   // Channel 1 relay and stop telegrams
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch1_dim_q      <= DIM_STOP;
         ch1_dim_send_q <= 1'b0;
      end else if (hit_up || hit_lo) begin
         ch1_dim_q      <= DIM_STOP; // see R1
         ch1_dim_send_q <= 1'b1;
      end else if (cmd_wr && pwdata[CMD_SHIFT] && shift_on) begin
         ch1_dim_q      <= pwdata[CMD_DIM_LO +: 4]; // see R14
         ch1_dim_send_q <= 1'b1;
      end else begin
         ch1_dim_send_q <= 1'b0;
      end
   end

   // Channel enables from configured count
   always_comb begin
      ch_en = 3'h1; // see R13
      case (ctrl_q[CTRL_NCH_LO +: 2])
         2'h2: ch_en = 3'h3;
         2'h3: ch_en = 3'h7;
         default: ch_en = 3'h1;
      endcase
   end

   // ==========================================================
   // Feedback object
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fb_value_q <= DEF_SETPOINT;
         fb_ev_q    <= 1'b0;
         fb_send_q  <= 1'b0;
      end else begin
         fb_value_q <= ctrl_q[CTRL_FB_EN] ? sp_q : 16'h0; // see R11
         // Send one cycle late so the new setpoint already stands on the value
         fb_ev_q    <= sp_chg || dl_ev || vr_ev;
         fb_send_q  <= ctrl_q[CTRL_FB_EN] && ctrl_q[CTRL_FB_ACTIVE] && fb_ev_q; // see R12
      end
   end

   // ==========================================================
   // Interrupt status, cleared by read, set wins
   assign ev = {fb_send_q, sp_chg, hit_lo, hit_up};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else if (stat_rd) begin
         stat_q <= ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end

   assign irq = |(stat_q & mask_q);

   // ==========================================================
   // Read mux
   always_comb begin
      prdata = 32'h0;
      mapped = 1'b1;
      case (paddr)
         LSM_CTRL_OFS:   prdata = {21'h0, ctrl_q};
         LSM_DEFSP_OFS:  prdata = {16'h0, defsp_q};
         LSM_ULIM_OFS:   prdata = {16'h0, ulim_q};
         LSM_LLIM_OFS:   prdata = {16'h0, llim_q};
         LSM_HYST_OFS:   prdata = {26'h0, hyst_q};
         LSM_MEAS_OFS:   prdata = {16'h0, meas_q};
         LSM_CMD_OFS:    prdata = 32'h0;
         LSM_PRESET_OFS: prdata = {16'h0, sp_q};
         LSM_SP_OFS:     prdata = {16'h0, sp_q};
         LSM_UPPER_OFS:  prdata = {15'h0, upper};
         LSM_STAT_OFS:   prdata = {27'h0, temp_q, shifting_q, learned_q, src_q};
         LSM_IRQ_OFS:    prdata = {28'h0, stat_q};
         LSM_MASK_OFS:   prdata = {28'h0, mask_q};
         LSM_FB_OFS:     prdata = {16'h0, fb_value_q};
         default: begin
            prdata = 32'h0;
            mapped = 1'b0;
         end
      endcase
   end

   assign pslverr = psel && penable && !mapped;
endmodule : lsm_top

/* File: sim/lsm_top_asserts.sv */
// Port assertions for the light setpoint manager
`timescale 1ns/1ps
module lsm_top_asserts import lsm_pkg::*; (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        irq,
   input wire logic [2:0]  ch_en,
   input wire logic [3:0]  ch1_dim_q,
   input wire logic        ch1_dim_send_q,
   input wire logic [15:0] fb_value_q,
   input wire logic        fb_send_q
);
   // ==========================================
   // Shadow of written configuration
   wire logic   acc = psel && penable && pwrite;
   logic [10:0] ctrl_q;
   logic [3:0]  mask_q;
   logic [15:0] pre_q;
   logic        act_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         mask_q <= 4'h0;
         pre_q  <= 16'h0;
         act_q  <= 1'b0;
      end else begin
         act_q <= ctrl_q[CTRL_FB_EN] && ctrl_q[CTRL_FB_ACTIVE];
         if (acc && paddr == LSM_CTRL_OFS) ctrl_q <= pwdata[10:0];
         if (acc && paddr == LSM_MASK_OFS) mask_q <= pwdata[3:0];
         if (acc && paddr == LSM_PRESET_OFS) pre_q <= pwdata[15:0];
      end
   end
   // ==========================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ch_en_shape: assert property (ch_en[0] && (!ch_en[2] || ch_en[1]))
      else $error("channel enables malformed");
   chk_ch_en_cfg: assert property (
      acc && paddr == LSM_CTRL_OFS && pwdata[9:8] == 2'h3 |=> ch_en == 3'h7)
      else $error("three channels not enabled");
   chk_stop_relay: assert property (
      acc && paddr == LSM_CMD_OFS && pwdata[CMD_SHIFT] && pwdata[10:8] == 3'h0
      && ctrl_q[CTRL_SHIFT_EN] |-> ##[1:2] ch1_dim_send_q && ch1_dim_q[2:0] == 3'h0)
      else $error("stop not relayed to channel 1");
   chk_fb_off: assert property (
      acc && paddr == LSM_CTRL_OFS && !pwdata[CTRL_FB_EN] |-> ##2 fb_value_q == 16'h0)
      else $error("feedback value shown while disabled");
   chk_fb_track: assert property (
      acc && paddr == LSM_PRESET_OFS && ctrl_q[CTRL_FB_EN] |-> ##2 fb_value_q == pre_q)
      else $error("feedback value does not follow setpoint");
   chk_fb_event: assert property (
      acc && paddr == LSM_CMD_OFS && (pwdata[CMD_DOWNLOAD] || pwdata[CMD_VRETURN])
      && ctrl_q[CTRL_FB_EN] && ctrl_q[CTRL_FB_ACTIVE] |-> ##[1:3] fb_send_q)
      else $error("feedback not sent after download or return");
   chk_fb_passive: assert property (
      !(ctrl_q[CTRL_FB_EN] && ctrl_q[CTRL_FB_ACTIVE]) && !act_q |-> !fb_send_q)
      else $error("feedback sent while passive");
   chk_irq_masked: assert property (mask_q == 4'h0 |-> !irq)
      else $error("interrupt raised while all masked");
   cover property (ch1_dim_send_q && ch1_dim_q[2:0] == 3'h0);
   cover property (fb_send_q);
   cover property (irq);
endmodule : lsm_top_asserts

/* File: sim/lsm_bus_model.sv */
// Far-side bus model: actuator telegram sink and phase end source
`timescale 1ns/1ps
module lsm_bus_model (
   input wire logic        pclk,
   input wire logic        ch1_dim_send_q,
   input wire logic [3:0]  ch1_dim_q,
   input wire logic        fb_send_q,
   input wire logic [15:0] fb_value_q,
   input wire logic        phase_req,
   output logic            phase_end_pin,
   output int              dim_cnt,
   output int              fb_cnt,
   output logic [3:0]      last_dim,
   output logic [15:0]     last_fb
);
   initial begin
      phase_end_pin = 1'b0;
      dim_cnt = 0;
      fb_cnt = 0;
      last_dim = 4'hf;
      last_fb = 16'h0;
   end
   always @(posedge pclk) begin
      if (ch1_dim_send_q === 1'b1) begin
         dim_cnt <= dim_cnt + 1;
         last_dim <= ch1_dim_q;
      end
      if (fb_send_q === 1'b1) begin
         fb_cnt <= fb_cnt + 1;
         last_fb <= fb_value_q;
      end
   end
   // Control phase end arrives unrelated to the clock
   always @(posedge phase_req) begin
      #13 phase_end_pin = 1'b1;
      repeat (4) @(posedge pclk);
      #29 phase_end_pin = 1'b0;
   end
endmodule : lsm_bus_model

/* File: sim/light_setpoint_manager_tb_top.sv */
// Self-checking bench for the light setpoint manager
`timescale 1ns/1ps
module light_setpoint_manager_tb_top import lsm_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sl;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [2:0]  ch_en;
   logic [3:0]  ch1_dim_q, last_dim;
   logic        ch1_dim_send_q, fb_send_q, phase_end_pin, phase_req;
   logic [15:0] fb_value_q, last_fb;
   int          dim_cnt, fb_cnt, err_count, compares, cyc, d, c, s, h, m;
   localparam logic [31:0] SE = 32'h1 << CTRL_SHIFT_EN, PM = 32'h1 << CTRL_PERM;
   localparam logic [31:0] TE = 32'h1 << CTRL_TEACH_EN, FE = 32'h1 << CTRL_FB_EN;
   localparam logic [31:0] FA = 32'h1 << CTRL_FB_ACTIVE, OV = 32'h1 << CTRL_OVR_DL;
   localparam logic [31:0] DEF = 32'(DEF_SETPOINT);
   logic [11:0] ra [6] = '{LSM_CTRL_OFS, LSM_DEFSP_OFS, LSM_ULIM_OFS,
                           LSM_LLIM_OFS, LSM_HYST_OFS, LSM_SP_OFS};
   logic [31:0] rx [6] = '{32'(CTRL_RST), DEF, 32'(DEF_ULIM), 32'(DEF_LLIM),
                           32'(DEF_HYST), DEF};
   lsm_top lsm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phase_end_pin(phase_end_pin), .irq(irq), .ch_en(ch_en),
      .ch1_dim_q(ch1_dim_q), .ch1_dim_send_q(ch1_dim_send_q), .fb_value_q(fb_value_q),
      .fb_send_q(fb_send_q));
   lsm_bus_model lsm_bus_model_inst (.pclk(pclk), .ch1_dim_send_q(ch1_dim_send_q),
      .ch1_dim_q(ch1_dim_q), .fb_send_q(fb_send_q), .fb_value_q(fb_value_q),
      .phase_req(phase_req), .phase_end_pin(phase_end_pin), .dim_cnt(dim_cnt),
      .fb_cnt(fb_cnt), .last_dim(last_dim), .last_fb(last_fb));
   // ==========================================
   // Clock, timeout and checking
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         test_done();
      end
   end
   task test_done;
      $display("Mismatches %0d, compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   function automatic logic [31:0] up_exp(int s, int h);
      int k;
      k = h < 10 ? 10 : (h > 50 ? 50 : h);
      return 32'(s + s * k / 100);
   endfunction : up_exp
   // ==========================================
   // APB master and command helpers
   task apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      sl = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] dt);
      apb(1'b1, a, dt);
   endtask : wr
   task rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task spc(input logic [31:0] e);
      rd(LSM_SP_OFS);
      chk(rv, e);
   endtask : spc
   task sh(input logic [3:0] code);
      wr(LSM_CMD_OFS, (32'h1 << CMD_SHIFT) | (32'(code) << CMD_DIM_LO));
   endtask : sh
   task tch(input logic v);
      wr(LSM_CMD_OFS, (32'h1 << CMD_TEACH) | (32'(v) << CMD_TEACH_VAL));
   endtask : tch
   task settle;
      repeat (3) @(negedge pclk);
   endtask : settle
   task phase;
      phase_req <= 1'b1;
      @(posedge pclk);
      phase_req <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask : phase
   // ==========================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, phase_req, presetn} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      void'($urandom(32'h13851b21));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         chk(rv, rx[i]);
      end
      rd(12'h100);
      chk({rv[30:0], sl}, 32'h1);
      for (int n = 1; n < 4; n++) begin
         wr(LSM_CTRL_OFS, 32'(n) << CTRL_NCH_LO);
         chk(32'(ch_en), n == 1 ? 32'h1 : (n == 2 ? 32'h3 : 32'h7));
      end
      for (int i = 0; i < 4; i++) begin
         h = i == 0 ? 60 : (i == 1 ? 5 : $urandom % 60);
         s = 100 + $urandom % 1900;
         wr(LSM_HYST_OFS, 32'(h));
         wr(LSM_PRESET_OFS, 32'(s));
         rd(LSM_UPPER_OFS);
         chk(rv, up_exp(s, h));
      end
      wr(LSM_CTRL_OFS, OV | FE | FA);
      wr(LSM_PRESET_OFS, 32'h12c);
      wr(LSM_CMD_OFS, 32'h1 << CMD_DOWNLOAD);
      spc(DEF);
      wr(LSM_CTRL_OFS, FE | FA);
      wr(LSM_PRESET_OFS, 32'h12c);
      wr(LSM_CMD_OFS, 32'h1 << CMD_DOWNLOAD);
      spc(32'h12c);
      s = 1000 + $urandom % 999;
      settle();
      c = fb_cnt;
      wr(LSM_PRESET_OFS, 32'(s));
      settle();
      chk(32'(fb_cnt - c), 32'h1);
      chk(32'(last_fb), 32'(s));
      wr(LSM_CTRL_OFS, FE);
      settle();
      c = fb_cnt;
      wr(LSM_PRESET_OFS, 32'(s + 1));
      settle();
      chk(32'(fb_cnt - c), 32'h0);
      rd(LSM_FB_OFS);
      chk(rv, 32'(s + 1));
      wr(LSM_ULIM_OFS, 32'h5dc);
      wr(LSM_LLIM_OFS, 32'h64);
      for (int k = 0; k < 2; k++) begin
         wr(LSM_CTRL_OFS, SE | PM);
         wr(LSM_MEAS_OFS, 32'h320);
         wr(LSM_PRESET_OFS, 32'h320);
         sh(k ? 4'h1 : 4'h9);
         settle();
         d = dim_cnt;
         wr(LSM_MEAS_OFS, k ? 32'h32 : 32'h640);
         settle();
         chk(32'(dim_cnt - d), 32'h1);
         chk(32'(last_dim[2:0]), 32'h0);
         spc(k ? 32'h64 : 32'h5dc);
         rd(LSM_IRQ_OFS);
         chk(32'(rv[k]), 32'h1);
         rd(LSM_IRQ_OFS);
         chk(32'(rv[k]), 32'h0);
      end
      wr(LSM_CTRL_OFS, SE);
      wr(LSM_MEAS_OFS, 32'h2bc);
      wr(LSM_PRESET_OFS, 32'h1f4);
      sh(4'h9);
      sh(4'h0);
      settle();
      chk(32'(last_dim[2:0]), 32'h0);
      spc(32'h2bc);
      phase();
      spc(32'h1f4);
      wr(LSM_CTRL_OFS, SE | PM);
      wr(LSM_MEAS_OFS, 32'h384);
      sh(4'h9);
      sh(4'h0);
      phase();
      wr(LSM_CMD_OFS, 32'h1 << CMD_VRETURN);
      spc(32'h384);
      wr(LSM_CMD_OFS, 32'h1 << CMD_RESET);
      spc(DEF);
      for (int p = 0; p < 3; p++) begin
         m = 1000 + $urandom % 999;
         wr(LSM_CTRL_OFS, TE | (32'(p) << CTRL_POL_LO));
         wr(LSM_MEAS_OFS, 32'(m));
         tch(p != 1);
         spc(32'(m));
         tch(p == 1);
         spc(p == 2 ? 32'(m) : DEF);
      end
      wr(LSM_CTRL_OFS, 32'h0);
      wr(LSM_MEAS_OFS, 32'h7b);
      tch(1'b1);
      spc(32'(m));
      wr(LSM_MASK_OFS, 32'h1 << IRQ_SPCH);
      rd(LSM_IRQ_OFS);
      chk(32'(irq), 32'h0);
      wr(LSM_PRESET_OFS, 32'h1bc);
      chk(32'(irq), 32'h1);
      wr(LSM_MASK_OFS, 32'h0);
      chk(32'(irq), 32'h0);
      wr(LSM_MASK_OFS, 32'h1 << IRQ_SPCH);
      chk(32'(irq), 32'h1);
      rd(LSM_IRQ_OFS);
      chk(32'(rv[IRQ_SPCH]), 32'h1);
      chk(32'(irq), 32'h0);
      test_done();
   end
endmodule : light_setpoint_manager_tb_top
bind lsm_top lsm_top_asserts lsm_top_asserts_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .irq(irq), .ch_en(ch_en), .ch1_dim_q(ch1_dim_q), .ch1_dim_send_q(ch1_dim_send_q),
   .fb_value_q(fb_value_q), .fb_send_q(fb_send_q));
